// *** design/pix_pack_pkg.sv ***
// package for the luma/chroma byte packer: types, orders, constants
// assumes one pixel clock shared by source, packer and transmitter
// Contract
// [R1] each pixel's 8-bit brightness goes out unchanged as its luma byte
// [R2] every chroma byte, blue or red difference, is zero in both orders
// [R3] one luma per pixel; one chroma pair per two pixels, from even pixel
// [R4] chroma-first: blue, even luma, red, odd luma; pairs back to back
// [R5] luma-first: even luma, blue, odd luma, red
// [R6] luma code is unsigned and equals the signal level, 0x00 to 0xFF
// [R7] chroma code is straight binary and always zero
// [R8] pixels go row by row; a row ends before the next begins
// [R9] first pixel of each frame is row zero, column zero
// [R10] columns go in ascending order within a row
// [R11] rows go in ascending order; last row index n gives n+1 lines
// [R12] pairs are consecutive pixels; frames hold an even pixel count
package pix_pack_pkg;
    localparam int unsigned PIX_W        = 8;
    localparam int unsigned COL_W        = 12;
    localparam int unsigned ROW_W        = 12;
    localparam logic [7:0]  CHROMA_ZERO  = 8'h00;
    localparam int unsigned FIFO_DEPTH   = 8;

    typedef enum logic {
        CHROMA_FIRST = 1'b0,
        LUMA_FIRST   = 1'b1
    } byte_order_t;

    // pixel entering from the sensor pipeline
    typedef struct packed {
        logic [PIX_W-1:0] level;
        logic             sof;
        logic             eol;
        logic             eof;
    } pixel_t;

    // byte leaving toward the frame transmitter
    typedef struct packed {
        logic [7:0] data;
        logic       sof;
        logic       eol;
        logic       eof;
    } out_byte_t;

    typedef enum logic [3:0] {
        ST_B0 = 4'b0001,
        ST_B1 = 4'b0010,
        ST_B2 = 4'b0100,
        ST_B3 = 4'b1000
    } slot_t;
endpackage

// *** design/pix_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
// assumes a single clock and async active-low reset
`timescale 1ns/1ps
`default_nettype none
module pix_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0]      cnt_ff, nxt_cnt;
    logic             push, pop;

    assign in_ready  = (cnt_ff != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_wr  = push ? ((wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + AW'(1)) : wr_ff;
        nxt_rd  = pop ? ((rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + AW'(1)) : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule // pix_fifo
`default_nettype wire

// *** design/mono_yuv422_byte_packer.sv ***
// packs mono pixels into a 4:2:2 byte stream with zero chroma
// assumes raster-ordered pixels from the pipeline on the same clock
`timescale 1ns/1ps
`default_nettype none
module mono_yuv422_byte_packer
(
    // clock and reset
    input  wire logic                      CLOCK,
    input  wire logic                      RESETN,
    // configuration
    input  wire pix_pack_pkg::byte_order_t ORDER,
    // pixel input
    input  wire logic                      PIX_VALID,
    output logic                           PIX_READY,
    input  wire pix_pack_pkg::pixel_t      PIX_IN,
    // byte output
    output logic                           BYTE_VALID,
    input  wire logic                      BYTE_READY,
    output pix_pack_pkg::out_byte_t        BYTE_OUT,
    // status
    output logic                           ORDER_ERR
);
    import pix_pack_pkg::*;

    localparam int unsigned OB_W = $bits(out_byte_t);

    slot_t            slot_ff, nxt_slot;
    logic [PIX_W-1:0] even_ff, nxt_even;
    byte_order_t      ord_ff, nxt_ord;
    logic             err_ff, nxt_err;
    out_byte_t        enc;
    logic             f_valid, f_ready;
    logic             take;

    // even pixel is latched, odd pixel completes the group
    assign take = PIX_VALID && PIX_READY;

    // only chroma-first slot B1 comes from the latched even pixel; luma in B0, B2 and B3 is taken from PIX_IN
    always_comb begin
        enc      = '0;
        f_valid  = 1'b0;
        PIX_READY = 1'b0;
        case (slot_ff)
            ST_B0: begin
                // [R4] [R5] first byte, order picked
                enc.data  = (ord_ff == LUMA_FIRST) ? PIX_IN.level : CHROMA_ZERO;
                // [R9] frame start on group's first byte
                enc.sof   = PIX_IN.sof;
                f_valid   = PIX_VALID;
                PIX_READY = f_ready;
            end
            ST_B1: begin
                // [R1] [R6] luma passes straight through
                enc.data = (ord_ff == LUMA_FIRST) ? CHROMA_ZERO : even_ff;
                f_valid  = 1'b1;
            end
            ST_B2: begin
                // [R2] [R7] chroma held at zero
                enc.data = (ord_ff == LUMA_FIRST) ? PIX_IN.level : CHROMA_ZERO;
                f_valid  = (ord_ff == LUMA_FIRST) ? PIX_VALID : 1'b1;
                PIX_READY = (ord_ff == LUMA_FIRST) ? f_ready : 1'b0;
            end
            ST_B3: begin
                enc.data  = (ord_ff == LUMA_FIRST) ? CHROMA_ZERO : PIX_IN.level;
                enc.eol   = PIX_IN.eol;
                enc.eof   = PIX_IN.eof;
                f_valid   = (ord_ff == LUMA_FIRST) ? 1'b1 : PIX_VALID;
                PIX_READY = (ord_ff == LUMA_FIRST) ? 1'b0 : f_ready;
            end
            default: begin
                enc = '0;
            end
        endcase
    end

    // odd pixel info for luma-first last byte is held from ST_B2
    logic [1:0] odd_flags_ff, nxt_odd_flags;

    always_comb begin
        nxt_slot      = slot_ff;
        nxt_even      = even_ff;
        nxt_ord       = ord_ff;
        nxt_err       = err_ff;
        nxt_odd_flags = odd_flags_ff;
        case (slot_ff)
            ST_B0: begin
                if (take) begin
                    // [R3] [R12] even pixel of the pair
                    nxt_even     = PIX_IN.level;
                    nxt_slot     = ST_B1;
                    // [R12] pair may not split at a row end
                    if (PIX_IN.eol || PIX_IN.eof) begin
                        nxt_err = 1'b1;
                    end
                end else begin
                    // order changes only between pairs
                    nxt_ord = ORDER;
                end
            end
            ST_B1: begin
                if (f_ready) begin
                    nxt_slot = ST_B2;
                end
            end
            ST_B2: begin
                if (f_valid && f_ready) begin
                    nxt_slot = ST_B3;
                    if (ord_ff == LUMA_FIRST) begin
                        nxt_odd_flags = {PIX_IN.eol, PIX_IN.eof};
                    end
                end
            end
            ST_B3: begin
                if (f_valid && f_ready) begin
                    // [R8] [R10] [R11] groups follow raster order
                    nxt_slot = ST_B0;
                    nxt_ord  = ORDER;
                end
            end
            default: begin
                nxt_slot = ST_B0;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            slot_ff      <= ST_B0;
            even_ff      <= '0;
            ord_ff       <= CHROMA_FIRST;
            err_ff       <= 1'b0;
            odd_flags_ff <= 2'b00;
        end else begin
            slot_ff      <= nxt_slot;
            even_ff      <= nxt_even;
            ord_ff       <= nxt_ord;
            err_ff       <= nxt_err;
            odd_flags_ff <= nxt_odd_flags;
        end
    end

    // final byte flags, luma-first takes the held odd flags
    out_byte_t fin;
    always_comb begin
        fin = enc;
        if (slot_ff == ST_B3 && ord_ff == LUMA_FIRST) begin
            fin.eol = odd_flags_ff[1];
            fin.eof = odd_flags_ff[0];
        end
    end

    assign ORDER_ERR = err_ff;

    pix_fifo #(
        .WIDTH (OB_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLOCK),
        .rst_n     (RESETN),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .in_data   (fin),
        .out_valid (BYTE_VALID),
        .out_ready (BYTE_READY),
        .out_data  (BYTE_OUT)
    );
endmodule // mono_yuv422_byte_packer
`default_nettype wire

// *** test/pack_props.sv ***
// checker for the byte packer ports
// assumes it is bound to mono_yuv422_byte_packer
`timescale 1ns/1ps
`default_nettype none
module pack_props
    import pix_pack_pkg::*;
(
    // clock and reset
    input wire logic                      CLOCK,
    input wire logic                      RESETN,
    // watched ports
    input wire pix_pack_pkg::byte_order_t ORDER,
    input wire logic                      PIX_VALID,
    input wire logic                      PIX_READY,
    input wire pix_pack_pkg::pixel_t      PIX_IN,
    input wire logic                      BYTE_VALID,
    input wire logic                      BYTE_READY,
    input wire pix_pack_pkg::out_byte_t   BYTE_OUT,
    input wire logic                      ORDER_ERR
);
    logic [1:0] pos_ff;
    logic [1:0] nxt_pos;
    // byte position within the group
    always_comb nxt_pos = pos_ff + {1'b0, BYTE_VALID && BYTE_READY};
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) pos_ff <= 2'h0;
        else pos_ff <= nxt_pos;
    end
    logic [2:0] took_ff;
    logic [2:0] nxt_took;
    // pixels taken in the three cycles before this one
    always_comb nxt_took = {took_ff[1:0], PIX_VALID && PIX_READY};
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) took_ff <= 3'h0;
        else took_ff <= nxt_took;
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    sequence take_s;
        BYTE_VALID && BYTE_READY;
    endsequence
    sequence chroma_s;
        take_s ##0 (pos_ff[0] == (ORDER == LUMA_FIRST));
    endsequence
    hold_out_a: assert property (BYTE_VALID && !BYTE_READY |=> BYTE_VALID && $stable(BYTE_OUT))
        else $error("output moved while stalled");
    chroma_zero_a: assert property (chroma_s |-> BYTE_OUT.data == CHROMA_ZERO)
        else $error("chroma byte not zero");
    sof_first_a: assert property (take_s ##0 BYTE_OUT.sof |-> pos_ff == 2'h0)
        else $error("frame start off group start");
    eol_last_a: assert property (take_s ##0 BYTE_OUT.eol |-> pos_ff == 2'h3)
        else $error("row end off group end");
    eof_last_a: assert property (take_s ##0 BYTE_OUT.eof |-> BYTE_OUT.eol && pos_ff == 2'h3)
        else $error("frame end misplaced");
    pix_rate_a: assert property ($countones({took_ff, PIX_VALID && PIX_READY}) <= 2)
        else $error("more than two pixels in four cycles");
    err_sticky_a: assert property (ORDER_ERR |=> ORDER_ERR)
        else $error("order flag dropped");
    reset_quiet_a: assert property ($rose(RESETN) |-> !BYTE_VALID && !ORDER_ERR)
        else $error("output busy after reset");
endmodule // pack_props
bind mono_yuv422_byte_packer pack_props chk_u (.CLOCK(CLOCK), .RESETN(RESETN), .ORDER(ORDER),
    .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_IN(PIX_IN), .BYTE_VALID(BYTE_VALID),
    .BYTE_READY(BYTE_READY), .BYTE_OUT(BYTE_OUT), .ORDER_ERR(ORDER_ERR));
`default_nettype wire

// *** test/byte_sink.sv ***
// frame transmitter model on the byte side
// assumes one clock shared with the packer
`timescale 1ns/1ps
`default_nettype none
module byte_sink (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pace and handshake
    input  wire logic stall,
    input  wire logic valid,
    output logic      ready
);
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    // pace counts only while a byte is offered
    always_comb nxt_cnt = valid ? cnt_ff + 2'h1 : cnt_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_ff <= 2'h0;
        else cnt_ff <= nxt_cnt;
    end
    // slow mode takes one byte in four cycles
    assign ready = !stall || (cnt_ff == 2'h3);
endmodule // byte_sink
`default_nettype wire

// *** test/mono_yuv422_byte_packer_test.sv ***
// self-checking bench for the byte packer
// assumes byte_sink paces the output side
`timescale 1ns/1ps
`default_nettype none
module mono_yuv422_byte_packer_test;
    import pix_pack_pkg::*;
    logic        CLOCK = 0, RESETN = 0, PIX_VALID = 0, STALL = 0;
    logic        PIX_READY, BYTE_VALID, BYTE_READY, ORDER_ERR;
    byte_order_t ORDER = CHROMA_FIRST;
    pixel_t      PIX_IN = '0;
    out_byte_t   BYTE_OUT;
    out_byte_t   rx[$], exp[$];
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    mono_yuv422_byte_packer dut_u (.CLOCK(CLOCK), .RESETN(RESETN), .ORDER(ORDER), .PIX_VALID(PIX_VALID),
        .PIX_READY(PIX_READY), .PIX_IN(PIX_IN), .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY),
        .BYTE_OUT(BYTE_OUT), .ORDER_ERR(ORDER_ERR));
    byte_sink sink_u (.clk(CLOCK), .rst_n(RESETN), .stall(STALL), .valid(BYTE_VALID), .ready(BYTE_READY));
    initial forever #20 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cyc++;
        if (BYTE_VALID && BYTE_READY) rx.push_back(BYTE_OUT);
        if (cyc == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic check(input logic [10:0] seen, input logic [10:0] want, input string what);
        n_tests++;
        if (seen !== want) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, seen, want);
        end
    endtask
    task automatic put(input pixel_t p);
        logic ok;
        PIX_IN = p;
        PIX_VALID = 1;
        do begin
            @(negedge CLOCK) ok = PIX_READY;
            @(posedge CLOCK) #1;
        end while (!ok);
    endtask
    task automatic frame(input byte_order_t ord, input int rows, input int cols, input logic [7:0] base,
                         input logic st);
        pixel_t     p;
        logic [7:0] lv[2];
        int         k;
        ORDER = ord;
        STALL = st;
        // one idle edge so the packer latches the new order
        @(posedge CLOCK) #1;
        rx.delete();
        exp.delete();
        for (k = 0; k < rows * cols; k++) begin
            p = '{8'(base + k * 61), k == 0, k % cols == cols - 1, k == rows * cols - 1};
            lv[k % 2] = p.level;
            if (k % 2) for (int j = 0; j < 4; j++)
                exp.push_back('{(j[0] != ord) ? lv[j / 2] : CHROMA_ZERO, k == 1 && j == 0, j == 3 && p.eol,
                                j == 3 && p.eof});
            put(p);
        end
        PIX_VALID = 0;
        for (k = 0; k < 3000 && rx.size() < exp.size(); k++) @(posedge CLOCK) #1;
        check(11'(rx.size()), 11'(exp.size()), "byte count");
        foreach (exp[i]) check(rx[i], exp[i], "byte");
        check({10'h0, BYTE_VALID}, 11'h0, "drained");
        check({10'h0, ORDER_ERR}, 11'h0, "no order flag");
        $display("frame %0dx%0d order %0d done", rows, cols, ord);
    endtask
    task automatic odd_row();
        ORDER = CHROMA_FIRST;
        put('{8'h11, 1'b1, 1'b0, 1'b0});
        put('{8'h22, 1'b0, 1'b0, 1'b0});
        put('{8'h33, 1'b0, 1'b1, 1'b1});
        PIX_VALID = 0;
        check({10'h0, ORDER_ERR}, 11'h1, "odd row flag");
        RESETN = 0;
        repeat (2) @(posedge CLOCK) #1;
        RESETN = 1;
        check({9'h0, ORDER_ERR, BYTE_VALID}, 11'h0, "after reset");
        $display("odd row done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge CLOCK);
        #1 RESETN = 1;
        frame(CHROMA_FIRST, 2, 4, 8'hFF, 1'b0);
        frame(LUMA_FIRST, 3, 2, 8'h00, 1'b1);
        frame(CHROMA_FIRST, 2, 6, 8'h80, 1'b1);
        odd_row();
        frame(LUMA_FIRST, 2, 2, 8'h7F, 1'b0);
        report_and_stop();
    end
endmodule // mono_yuv422_byte_packer_test
`default_nettype wire
